//--- swstat_pkg.sv
// Purpose: shared constants for the switch port statistics counter bank
// Assumes: apb register index = byte address / 4
// Notes:   counter offsets are relative to a port base
package swstat_pkg;
  localparam int NPORT = 5;
  localparam int NCNT = 32;
  localparam int NDROP = 10;
  localparam int LENW = 11;
  localparam int INCW = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TBL_SELECT = 8'h6e;
  localparam logic [7:0] IDX_TBL_OFFSET = 8'h6f;
  localparam logic [7:0] IDX_DATA_3 = 8'h75;
  localparam logic [7:0] IDX_DATA_2 = 8'h76;
  localparam logic [7:0] IDX_DATA_1 = 8'h77;
  localparam logic [7:0] IDX_DATA_0 = 8'h78;
  localparam logic [7:0] IDX_SIZE_CFG = 8'h7f;
  // table select codes
  localparam logic [7:0] SEL_PORT_CNT = 8'h1c;
  localparam logic [7:0] SEL_DROP_CNT = 8'h1d;
  // address map of the indirect memory
  localparam logic [7:0] PORT_BASE_STEP = 8'h20;
  localparam logic [7:0] PORT_LAST_END = 8'h9f;
  localparam int OVF_BIT = 31;
  localparam int VALID_BIT = 30;
  localparam int CNT_W = 30;
  localparam int DROP_W = 16;
  localparam logic [31:0] SNAP_RESET = 32'h0000_0000;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic SIZE_CFG_RESET = 1'b0;
  // frame length limits
  localparam logic [LENW-1:0] LEN_MIN = 11'h040;
  localparam logic [LENW-1:0] LEN_MAX_STD = 11'h5f2;
  localparam logic [LENW-1:0] LEN_MAX_BIG = 11'h600;
  localparam logic [LENW-1:0] LEN_BIN1 = 11'h07f;
  localparam logic [LENW-1:0] LEN_BIN2 = 11'h0ff;
  localparam logic [LENW-1:0] LEN_BIN3 = 11'h1ff;
  localparam logic [LENW-1:0] LEN_BIN4 = 11'h3ff;
  localparam logic [15:0] ETYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] OPCODE_PAUSE = 16'h0001;
  // per-port counter offsets
  localparam logic [4:0] C_RX_LO_OCT = 5'h00;
  localparam logic [4:0] C_RX_HI_OCT = 5'h01;
  localparam logic [4:0] C_RX_SHORT_GOOD = 5'h02;
  localparam logic [4:0] C_RX_SHORT_BAD = 5'h03;
  localparam logic [4:0] C_RX_LONG_GOOD = 5'h04;
  localparam logic [4:0] C_RX_LONG_BAD = 5'h05;
  localparam logic [4:0] C_RX_BAD_SYM = 5'h06;
  localparam logic [4:0] C_RX_CRC_FAIL = 5'h07;
  localparam logic [4:0] C_RX_MISALIGN = 5'h08;
  localparam logic [4:0] C_RX_MAC_CTRL = 5'h09;
  localparam logic [4:0] C_RX_PAUSE = 5'h0a;
  localparam logic [4:0] C_RX_BCAST = 5'h0b;
  localparam logic [4:0] C_RX_MCAST = 5'h0c;
  localparam logic [4:0] C_RX_UCAST = 5'h0d;
  localparam logic [4:0] C_RX_BIN64 = 5'h0e;
  localparam logic [4:0] C_RX_BIN127 = 5'h0f;
  localparam logic [4:0] C_RX_BIN255 = 5'h10;
  localparam logic [4:0] C_RX_BIN511 = 5'h11;
  localparam logic [4:0] C_RX_BIN1023 = 5'h12;
  localparam logic [4:0] C_RX_BINMAX = 5'h13;
  localparam logic [4:0] C_TX_LO_OCT = 5'h14;
  localparam logic [4:0] C_TX_HI_OCT = 5'h15;
  localparam logic [4:0] C_TX_LATE_COL = 5'h16;
  localparam logic [4:0] C_TX_PAUSE = 5'h17;
  localparam logic [4:0] C_TX_BCAST = 5'h18;
  localparam logic [4:0] C_TX_MCAST = 5'h19;
  localparam logic [4:0] C_TX_UCAST = 5'h1a;
  localparam logic [4:0] C_TX_DEFERRED = 5'h1b;
  localparam logic [4:0] C_TX_ALL_COL = 5'h1c;
  localparam logic [4:0] C_TX_EXCESS = 5'h1d;
  localparam logic [4:0] C_TX_ONE_COL = 5'h1e;
  localparam logic [4:0] C_TX_MANY_COL = 5'h1f;
endpackage

//--- swstat_top.sv
// Purpose: statistics counter bank for a five-port switch, apb register access
// Assumes: event inputs come from mac logic on pclk, one-cycle pulses
// Notes:   per-port counters clear on read, drop counters do not
// Behaviour
// - 32 counters per port, bases 0x20 apart
// - rx octets by priority, bad included
// - short frames: good at 0x2, bad at 0x3
// - long good frames beyond size limit
// - long errored frames beyond size limit
// - legal-length frames with invalid symbol
// - bad checksum: whole bytes 0x7, else 0x8
// - count mac control ethertype frames
// - count fully qualified pause frames
// - good rx broadcast, multicast, unicast counts
// - rx length bins, bad frames included
// - good tx octets by priority, pause included
// - late collisions past 512 bit-times
// - tx pause, broadcast, multicast, unicast counts
// - deferral, collision and retry outcome counts
// - word: overflow, valid, 30-bit count
// - ten 16-bit drop counters, select 0x1d, offsets 0-9
// - reading a per-port counter clears it
// - drop counters keep value, no flags
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module swstat_top
(
  // clock and reset
  input  wire logic                                         pclk,
  input  wire logic                                         presetn,
  // apb slave
  input  wire logic                                         psel,
  input  wire logic                                         penable,
  input  wire logic                                         pwrite,
  input  wire logic [11:0]                                  paddr,
  input  wire logic [31:0]                                  pwdata,
  output logic                                              pready,
  output logic                                              pslverr,
  output logic [31:0]                                       prdata,
  // receive frame report, one pulse per frame per port
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_done,
  input  wire logic [swstat_pkg::NPORT*swstat_pkg::LENW-1:0] rx_len,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_crc_ok,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_odd_bits,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_symbol_err,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_align_err,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_high_prio,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_bcast,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_mcast,
  input  wire logic [swstat_pkg::NPORT*16-1:0]              rx_ethertype,
  input  wire logic [swstat_pkg::NPORT*16-1:0]              rx_opcode,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_pause_da,
  // transmit frame report, one pulse per frame per port
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_done,
  input  wire logic [swstat_pkg::NPORT*swstat_pkg::LENW-1:0] tx_len,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_ok,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_high_prio,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_bcast,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_mcast,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_pause,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_deferred,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_excess_col,
  input  wire logic [swstat_pkg::NPORT*5-1:0]               tx_col_count,
  // transmit collision pulses, any time
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_collision,
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_late_collision,
  // drops for lack of resources
  input  wire logic [swstat_pkg::NPORT-1:0]                 tx_drop,
  input  wire logic [swstat_pkg::NPORT-1:0]                 rx_drop
);

  logic [7:0]                           idx;
  logic                                 wr_en;
  logic                                 rd_setup;
  logic                                 mapped;
  logic [7:0]                           select_q;
  logic [7:0]                           offset_q;
  logic                                 size_cfg_q;
  logic [31:0]                          snap_q;
  logic [31:0]                          rdata_d;
  logic [31:0]                          prdata_q;
  logic                                 trig;
  logic                                 port_trig;
  logic [2:0]                           trig_port;
  logic [4:0]                           trig_cnt;
  logic [swstat_pkg::LENW-1:0]          max_len;
  logic [swstat_pkg::CNT_W:0]           port_word [swstat_pkg::NPORT];
  logic [swstat_pkg::DROP_W-1:0]        drop_q [swstat_pkg::NDROP];
  logic [swstat_pkg::NPORT*2-1:0]       drop_ev;

  assign idx      = paddr[9:2];
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_q;

  always_comb
  begin
    case (idx)
      swstat_pkg::IDX_TBL_SELECT,
      swstat_pkg::IDX_TBL_OFFSET,
      swstat_pkg::IDX_DATA_3,
      swstat_pkg::IDX_DATA_2,
      swstat_pkg::IDX_DATA_1,
      swstat_pkg::IDX_DATA_0,
      swstat_pkg::IDX_SIZE_CFG: mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
      default:                  mapped = 1'b0;
    endcase
  end

  // unmapped or misaligned accesses are flagged, writes to them dropped
  assign pslverr = psel & penable & ~mapped;

  // the size limit picks 1536 when set, 1522 otherwise
  assign max_len = size_cfg_q ? swstat_pkg::LEN_MAX_BIG : swstat_pkg::LEN_MAX_STD;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_q   <= swstat_pkg::SELECT_RESET;
      offset_q   <= swstat_pkg::SELECT_RESET;
      size_cfg_q <= swstat_pkg::SIZE_CFG_RESET;
    end
    else if (wr_en && mapped)
    begin
      if (idx == swstat_pkg::IDX_TBL_SELECT)
        select_q <= pwdata[7:0];
      if (idx == swstat_pkg::IDX_TBL_OFFSET)
        offset_q <= pwdata[7:0];
      if (idx == swstat_pkg::IDX_SIZE_CFG)
        size_cfg_q <= pwdata[0];
    end
  end

  // writing the offset launches the indirect read
  assign trig      = wr_en && mapped && (idx == swstat_pkg::IDX_TBL_OFFSET);
  assign trig_port = 3'(pwdata[7:5]);
  assign trig_cnt  = pwdata[4:0];
  assign port_trig = trig && (select_q == swstat_pkg::SEL_PORT_CNT)
                     && (pwdata[7:0] <= swstat_pkg::PORT_LAST_END);

  // snapshot of the addressed word, read back a byte at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snap_q <= swstat_pkg::SNAP_RESET;
    else if (trig && select_q == swstat_pkg::SEL_PORT_CNT)
    begin
      if (port_trig)
        snap_q <= {port_word[trig_port][swstat_pkg::CNT_W], 1'b1,
                   port_word[trig_port][swstat_pkg::CNT_W-1:0]};
      else
        snap_q <= swstat_pkg::SNAP_RESET;
    end
    else if (trig && select_q == swstat_pkg::SEL_DROP_CNT)
    begin
      if (pwdata[7:0] < 8'(swstat_pkg::NDROP))
        snap_q <= {16'h0000, drop_q[pwdata[3:0]]};
      else
        snap_q <= swstat_pkg::SNAP_RESET;
    end
  end

  always_comb
  begin
    case (idx)
      swstat_pkg::IDX_TBL_SELECT: rdata_d = {24'h0, select_q};
      swstat_pkg::IDX_TBL_OFFSET: rdata_d = {24'h0, offset_q};
      swstat_pkg::IDX_DATA_3:     rdata_d = {24'h0, snap_q[31:24]};
      swstat_pkg::IDX_DATA_2:     rdata_d = {24'h0, snap_q[23:16]};
      swstat_pkg::IDX_DATA_1:     rdata_d = {24'h0, snap_q[15:8]};
      swstat_pkg::IDX_DATA_0:     rdata_d = {24'h0, snap_q[7:0]};
      swstat_pkg::IDX_SIZE_CFG:   rdata_d = {31'h0, size_cfg_q};
      default:                    rdata_d = 32'h0;
    endcase
  end

  // read data taken at setup, so no wait state is needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (rd_setup)
      prdata_q <= mapped ? rdata_d : 32'h0;
  end

  genvar p;
  generate
    for (p = 0; p < swstat_pkg::NPORT; p++)
    begin : g_port
      logic [swstat_pkg::CNT_W:0]       cnt_q [swstat_pkg::NCNT];
      logic [swstat_pkg::CNT_W:0]       sum   [swstat_pkg::NCNT];
      logic [swstat_pkg::INCW-1:0]      inc   [swstat_pkg::NCNT];
      logic [swstat_pkg::LENW-1:0]      rlen;
      logic [swstat_pkg::LENW-1:0]      tlen;
      logic                             rx_err;
      logic                             legal;
      logic                             good;
      logic                             ctrl;
      logic [4:0]                       ncol;
      logic                             clr;

      assign rlen   = rx_len[p*swstat_pkg::LENW +: swstat_pkg::LENW];
      assign tlen   = tx_len[p*swstat_pkg::LENW +: swstat_pkg::LENW];
      assign ncol   = tx_col_count[p*5 +: 5];
      assign rx_err = ~rx_crc_ok[p] | rx_symbol_err[p] | rx_align_err[p];
      assign legal  = (rlen >= swstat_pkg::LEN_MIN) && (rlen <= max_len);
      assign good   = ~rx_err & legal;
      assign ctrl   = rx_ethertype[p*16 +: 16] == swstat_pkg::ETYPE_MAC_CTRL;
      assign clr    = port_trig && (trig_port == 3'(p));

      always_comb
      begin
        for (int k = 0; k < swstat_pkg::NCNT; k++)
          inc[k] = 12'h000;
        if (rx_done[p])
        begin
          inc[rx_high_prio[p] ? swstat_pkg::C_RX_HI_OCT : swstat_pkg::C_RX_LO_OCT] = {1'b0, rlen};
          if (rlen < swstat_pkg::LEN_MIN)
            inc[rx_err ? swstat_pkg::C_RX_SHORT_BAD : swstat_pkg::C_RX_SHORT_GOOD] = 12'h001;
          if (rlen > max_len)
            inc[rx_err ? swstat_pkg::C_RX_LONG_BAD : swstat_pkg::C_RX_LONG_GOOD] = 12'h001;
          if (legal && rx_symbol_err[p])
            inc[swstat_pkg::C_RX_BAD_SYM] = 12'h001;
          if (legal && !rx_crc_ok[p])
            inc[rx_odd_bits[p] ? swstat_pkg::C_RX_MISALIGN : swstat_pkg::C_RX_CRC_FAIL] = 12'h001;
          if (ctrl)
            inc[swstat_pkg::C_RX_MAC_CTRL] = 12'h001;
          if (ctrl && rx_pause_da[p] && rx_opcode[p*16 +: 16] == swstat_pkg::OPCODE_PAUSE
              && rlen >= swstat_pkg::LEN_MIN && rx_crc_ok[p])
            inc[swstat_pkg::C_RX_PAUSE] = 12'h001;
          if (good)
          begin
            if (rx_bcast[p])
              inc[swstat_pkg::C_RX_BCAST] = 12'h001;
            else if (rx_mcast[p])
            begin
              if (!ctrl)
                inc[swstat_pkg::C_RX_MCAST] = 12'h001;
            end
            else
              inc[swstat_pkg::C_RX_UCAST] = 12'h001;
          end
          // length bins, bad frames included
          if (rlen == swstat_pkg::LEN_MIN)
            inc[swstat_pkg::C_RX_BIN64] = 12'h001;
          else if (rlen > swstat_pkg::LEN_MIN && rlen <= swstat_pkg::LEN_BIN1)
            inc[swstat_pkg::C_RX_BIN127] = 12'h001;
          else if (rlen > swstat_pkg::LEN_BIN1 && rlen <= swstat_pkg::LEN_BIN2)
            inc[swstat_pkg::C_RX_BIN255] = 12'h001;
          else if (rlen > swstat_pkg::LEN_BIN2 && rlen <= swstat_pkg::LEN_BIN3)
            inc[swstat_pkg::C_RX_BIN511] = 12'h001;
          else if (rlen > swstat_pkg::LEN_BIN3 && rlen <= swstat_pkg::LEN_BIN4)
            inc[swstat_pkg::C_RX_BIN1023] = 12'h001;
          else if (rlen > swstat_pkg::LEN_BIN4 && rlen <= max_len)
            inc[swstat_pkg::C_RX_BINMAX] = 12'h001;
        end
        if (tx_done[p])
        begin
          if (tx_ok[p])
          begin
            inc[tx_high_prio[p] ? swstat_pkg::C_TX_HI_OCT : swstat_pkg::C_TX_LO_OCT] = {1'b0, tlen};
            if (tx_pause[p])
              inc[swstat_pkg::C_TX_PAUSE] = 12'h001;
            if (tx_bcast[p])
              inc[swstat_pkg::C_TX_BCAST] = 12'h001;
            else if (tx_mcast[p])
              inc[swstat_pkg::C_TX_MCAST] = 12'h001;
            else
              inc[swstat_pkg::C_TX_UCAST] = 12'h001;
            if (ncol == 5'h01)
              inc[swstat_pkg::C_TX_ONE_COL] = 12'h001;
            else if (ncol > 5'h01)
              inc[swstat_pkg::C_TX_MANY_COL] = 12'h001;
          end
          else if (tx_excess_col[p])
            inc[swstat_pkg::C_TX_EXCESS] = 12'h001;
          if (tx_deferred[p])
            inc[swstat_pkg::C_TX_DEFERRED] = 12'h001;
        end
        // collision pulses arrive during the frame, not with its report
        if (tx_late_collision[p])
          inc[swstat_pkg::C_TX_LATE_COL] = 12'h001;
        if (tx_collision[p])
          inc[swstat_pkg::C_TX_ALL_COL] = 12'h001;
      end

      always_comb
      begin
        for (int k = 0; k < swstat_pkg::NCNT; k++)
          sum[k] = {1'b0, cnt_q[k][swstat_pkg::CNT_W-1:0]} + {19'h0, inc[k]};
      end

      // bit 30 of each entry is the sticky overflow flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          for (int k = 0; k < swstat_pkg::NCNT; k++)
            cnt_q[k] <= 31'h0;
        end
        else
        begin
          for (int k = 0; k < swstat_pkg::NCNT; k++)
          begin
            // an event in the clearing cycle is kept, not lost
            if (clr && trig_cnt == 5'(k))
              cnt_q[k] <= {1'b0, 18'h0, inc[k]};
            else
              cnt_q[k] <= {cnt_q[k][swstat_pkg::CNT_W] | sum[k][swstat_pkg::CNT_W],
                           sum[k][swstat_pkg::CNT_W-1:0]};
          end
        end
      end

      assign port_word[p] = cnt_q[trig_cnt];
      assign drop_ev[p] = tx_drop[p];
      assign drop_ev[p+swstat_pkg::NPORT] = rx_drop[p];
    end
  endgenerate

  genvar d;
  generate
    for (d = 0; d < swstat_pkg::NDROP; d++)
    begin : g_drop
      // plain 16-bit wrap; software keeps track of overflow itself
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          drop_q[d] <= 16'h0000;
        else if (drop_ev[d])
          drop_q[d] <= drop_q[d] + 16'h0001;
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- swstat_properties.sv
// Purpose: bound checker for the counter bank register side
// Assumes: zero wait state slave, select code tracked here
// Notes:   overflow flag is not predicted, it needs 2^30 events
`timescale 1ns/1ps
`default_nettype none
module swstat_properties
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  logic [7:0] sel_q;
  logic [1:0] kind_q;
  logic       acc;
  logic       wr;
  logic       rd;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sel_q <= 8'h00;
    else if (wr && paddr == 12'h1b8)
      sel_q <= pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      kind_q <= 2'h0;
    else if (wr && paddr == 12'h1bc && sel_q == 8'h1d)
      kind_q <= 2'h2;
    else if (wr && paddr == 12'h1bc && sel_q == 8'h1c)
      kind_q <= (pwdata[7:0] <= 8'h9f) ? 2'h1 : 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready; endproperty
  property p_err_phase; pslverr |-> acc; endproperty
  property p_err_read; rd && pslverr |-> prdata == 32'h0; endproperty
  property p_misalign; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  property p_load; !$stable(prdata) |-> $past(psel && !penable && !pwrite); endproperty
  property p_valid; rd && paddr == 12'h1d4 && kind_q == 2'h1 |-> prdata[6] && prdata[31:8] == 24'h0; endproperty
  property p_drop_hi; rd && kind_q == 2'h2 && paddr inside {12'h1d4, 12'h1d8} |-> prdata == 32'h0; endproperty
  property p_sel_back; rd && paddr == 12'h1b8 |-> prdata == {24'h0, sel_q}; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  a_err_read: assert property (p_err_read) else $error("refused read not zero");
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  a_load: assert property (p_load) else $error("prdata moved without read setup");
  a_valid: assert property (p_valid) else $error("valid flag clear in port word");
  a_drop_hi: assert property (p_drop_hi) else $error("drop word upper bytes set");
  a_sel_back: assert property (p_sel_back) else $error("select readback wrong");
  c_port: cover property (rd && paddr == 12'h1d4 && kind_q == 2'h1);
  c_drop: cover property (rd && paddr == 12'h1e0 && kind_q == 2'h2);
  c_err: cover property (rd && pslverr);
endmodule
bind swstat_top swstat_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .prdata);
`default_nettype wire

//--- swstat_host.sv
// Purpose: host model driving the counter bank over apb
// Assumes: each wait for pready is bounded
// Notes:   drop words fetch only the two low data bytes
`timescale 1ns/1ps
`default_nettype none
module swstat_host
(
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  logic stuck = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    stuck <= (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic counter(input logic [7:0] sel, input logic [7:0] off, output logic [31:0] w);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, 12'h1b8, {24'h0, sel}, r, e);
    xfer(1'b1, 12'h1bc, {24'h0, off}, r, e);
    w = '0;
    for (int i = (sel == 8'h1d) ? 2 : 0; i < 4; i++)
    begin
      xfer(1'b0, 12'h1d4 + {i[9:0], 2'h0}, 32'h0, r, e);
      w = {w[23:0], r[7:0]};
    end
  endtask
endmodule
`default_nettype wire

//--- swstat_tb_top.sv
// Purpose: self-checking bench for the counter bank
// Assumes: all apb traffic goes through the host model
// Notes:   counter wrap is not checked, too slow here and not predicted by the checker
`timescale 1ns/1ps
`default_nettype none
module swstat_tb_top;
  localparam logic [7:0] dr = 8'h1d;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0]  rx_done, rx_crc_ok, rx_odd_bits, rx_symbol_err, rx_align_err, rx_high_prio, rx_bcast;
  logic [4:0]  rx_mcast, rx_pause_da, tx_done, tx_ok, tx_high_prio, tx_bcast, tx_mcast, tx_pause;
  logic [4:0]  tx_deferred, tx_excess_col, tx_collision, tx_late_collision, tx_drop, rx_drop;
  logic [54:0] rx_len, tx_len;
  logic [79:0] rx_ethertype, rx_opcode;
  logic [24:0] tx_col_count;
  int          mismatches = 0;
  int          compares = 0;
  always #12.5 pclk = ~pclk;
  swstat_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);
  swstat_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .rx_done, .rx_len, .rx_crc_ok, .rx_odd_bits, .rx_symbol_err, .rx_align_err, .rx_high_prio, .rx_bcast,
    .rx_mcast, .rx_ethertype, .rx_opcode, .rx_pause_da, .tx_done, .tx_len, .tx_ok, .tx_high_prio, .tx_bcast,
    .tx_mcast, .tx_pause, .tx_deferred, .tx_excess_col, .tx_col_count, .tx_collision, .tx_late_collision,
    .tx_drop, .rx_drop);
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cnt(input logic [7:0] off, input logic [31:0] exp, input string nm, input logic [7:0] sel = 8'h1c);
    logic [31:0] w;
    u_host.counter(sel, off, w);
    check(nm, w, exp);
  endtask
  // f: crc_ok, odd, symbol, align, high, bcast, mcast, pause_da; nonzero op marks a control frame
  task automatic rx(input int p, input logic [10:0] len, input logic [7:0] f, input logic [15:0] op = 16'h0);
    @(posedge pclk);
    rx_done[p] <= 1'b1;
    rx_len[p*11+:11] <= len;
    {rx_crc_ok[p], rx_odd_bits[p], rx_symbol_err[p], rx_align_err[p]} <= f[7:4];
    {rx_high_prio[p], rx_bcast[p], rx_mcast[p], rx_pause_da[p]} <= f[3:0];
    rx_ethertype[p*16+:16] <= (op == 16'h0) ? 16'h0800 : 16'h8808;
    rx_opcode[p*16+:16] <= op;
    @(posedge pclk);
    rx_done <= 5'h00;
  endtask
  // f: ok, high, bcast, mcast, pause, deferred, excess
  task automatic tx(input int p, input logic [10:0] len, input logic [6:0] f, input logic [4:0] cc);
    @(posedge pclk);
    tx_done[p] <= 1'b1;
    tx_len[p*11+:11] <= len;
    tx_col_count[p*5+:5] <= cc;
    {tx_ok[p], tx_high_prio[p], tx_bcast[p], tx_mcast[p]} <= f[6:3];
    {tx_pause[p], tx_deferred[p], tx_excess_col[p]} <= f[2:0];
    @(posedge pclk);
    tx_done <= 5'h00;
  endtask
  task automatic pulse(input int k, input int p);
    @(posedge pclk);
    case (k)
      0: tx_late_collision[p] <= 1'b1;
      1: tx_drop[p] <= 1'b1;
      2: rx_drop[p] <= 1'b1;
      default: tx_collision[p] <= 1'b1;
    endcase
    @(posedge pclk);
    {tx_late_collision, tx_drop, rx_drop, tx_collision} <= '0;
  endtask
  always @(posedge pclk)
    if (u_host.stuck === 1'b1)
    begin
      mismatches++;
      wrap_up();
    end
  initial
  begin
    {rx_done, rx_crc_ok, rx_odd_bits, rx_symbol_err, rx_align_err, rx_high_prio, rx_bcast, rx_mcast} = '0;
    {rx_pause_da, tx_done, tx_ok, tx_high_prio, tx_bcast, tx_mcast, tx_pause, tx_deferred} = '0;
    {tx_excess_col, tx_collision, tx_late_collision, tx_drop, rx_drop, tx_col_count} = '0;
    {rx_len, tx_len, rx_ethertype, rx_opcode} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    u_host.xfer(1'b0, 12'h1d4, 32'h0, r, e);
    check("data_before_trigger", r, 32'h0);
    rx(0, 11'h040, 8'h80);
    cnt(8'h00, 32'h4000_0040, "p1_rx_lo_octets");
    cnt(8'h00, 32'h4000_0000, "p1_rx_lo_cleared");
    cnt(8'h0e, 32'h4000_0001, "p1_bin64");
    cnt(8'h0d, 32'h4000_0001, "p1_ucast");
    rx(0, 11'h028, 8'h80);
    rx(0, 11'h032, 8'h90);
    rx(0, 11'h5fa, 8'h80);
    rx(0, 11'h640, 8'h00);
    rx(0, 11'h0c8, 8'ha0);
    cnt(8'h02, 32'h4000_0001, "p1_short_good");
    cnt(8'h03, 32'h4000_0001, "p1_short_bad");
    cnt(8'h04, 32'h4000_0001, "p1_long_good");
    cnt(8'h05, 32'h4000_0001, "p1_long_bad");
    cnt(8'h06, 32'h4000_0001, "p1_bad_symbol");
    rx(1, 11'h064, 8'h48);
    cnt(8'h28, 32'h4000_0001, "p2_misaligned");
    cnt(8'h27, 32'h4000_0000, "p2_crc_whole");
    cnt(8'h21, 32'h4000_0064, "p2_rx_hi_octets");
    cnt(8'h2d, 32'h4000_0000, "p2_ucast_bad");
    cnt(8'h2f, 32'h4000_0001, "p2_bin127");
    rx(2, 11'h040, 8'h85, 16'h0001);
    rx(2, 11'h040, 8'h83, 16'h0002);
    cnt(8'h49, 32'h4000_0002, "p3_mac_ctrl");
    cnt(8'h4a, 32'h4000_0001, "p3_pause");
    cnt(8'h4c, 32'h4000_0000, "p3_mcast_ctrl");
    cnt(8'h4b, 32'h4000_0001, "p3_bcast");
    u_host.xfer(1'b1, 12'h1fc, 32'h1, r, e);
    u_host.xfer(1'b0, 12'h1fc, 32'h0, r, e);
    check("size_cfg", r, 32'h1);
    rx(0, 11'h5fa, 8'h82);
    cnt(8'h04, 32'h4000_0000, "p1_long_big_limit");
    cnt(8'h13, 32'h4000_0001, "p1_bin_max");
    cnt(8'h0c, 32'h4000_0001, "p1_mcast");
    tx(4, 11'h0c8, 7'h52, 5'h01);
    tx(4, 11'h12c, 7'h01, 5'h10);
    tx(4, 11'h040, 7'h64, 5'h00);
    tx(4, 11'h064, 7'h48, 5'h03);
    pulse(0, 4);
    pulse(3, 4);
    pulse(3, 4);
    cnt(8'h94, 32'h4000_012c, "p5_tx_lo_octets");
    cnt(8'h95, 32'h4000_0040, "p5_tx_hi_octets");
    cnt(8'h97, 32'h4000_0001, "p5_tx_pause");
    cnt(8'h98, 32'h4000_0001, "p5_tx_bcast");
    cnt(8'h99, 32'h4000_0001, "p5_tx_mcast");
    cnt(8'h9b, 32'h4000_0001, "p5_deferred");
    cnt(8'h9d, 32'h4000_0001, "p5_excess");
    cnt(8'h9e, 32'h4000_0001, "p5_one_col");
    cnt(8'h9f, 32'h4000_0001, "p5_many_col");
    cnt(8'h96, 32'h4000_0001, "p5_late_col");
    cnt(8'h9c, 32'h4000_0002, "p5_all_col");
    pulse(1, 0);
    pulse(1, 0);
    pulse(2, 4);
    cnt(8'h00, 32'h0000_0002, "p1_tx_drop", dr);
    cnt(8'h00, 32'h0000_0002, "p1_tx_drop_kept", dr);
    cnt(8'h09, 32'h0000_0001, "p5_rx_drop", dr);
    cnt(8'ha0, 32'h0000_0000, "beyond_last_port");
    u_host.xfer(1'b0, 12'h010, 32'h0, r, e);
    check("unmapped_err", {31'h0, e}, 32'h1);
    check("unmapped_data", r, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
